// File: core/bmsg_backup_gating.sv
`timescale 1ns/1ps
// What this block does
// - bits 0,0: standard switchover, serial interface stays usable on battery
// - inhibit 0, select 1: legacy switchover, serial stays usable on battery
// - inhibit 1, select 0: standard switchover, serial off during backup
// - bits 1,1: legacy switchover, serial off during backup
// - standard: backup when main below lower of trip threshold and battery
// - legacy: backup when main below battery, trip threshold ignored
// - inhibit modes disable serial interface on entering backup
// - interrupt/frequency output keeps working in backup in every mode
// - after power-up the standard switchover mode is selected
module bmsg_backup_gating (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // mode configuration from the control register file
    input wire logic i_cfg_we,
    input wire bmsg_pkg::bmsg_cfg_s i_cfg,
    // analog comparator results (asynchronous)
    input wire bmsg_pkg::bmsg_cmp_s i_cmp,
    // interrupt/frequency source from the alarm and divider logic
    input wire logic i_interrupt_or_freq_output_assert,
    // state and gating outputs
    output bmsg_pkg::bmsg_cfg_s o_cfg,
    output logic o_on_battery,
    output logic o_serial_enable,
    output logic o_nvm_access_ok,
    // open-drain interrupt_or_freq_output pin
    output logic o_interrupt_or_freq_output,
    output logic o_interrupt_or_freq_output_oe
);
    import bmsg_pkg::*;

    bmsg_cfg_s cfg_q;
    bmsg_state_e state_q;
    bmsg_state_e state_d;
    logic below_trip_s;
    logic below_batt_s;
    logic standard_trip;
    logic legacy_trip;
    logic switch_cond;
    logic in_backup_d;
    logic serial_en_d;
    logic fout_drive_q;

    // comparator levels cross into the clock domain before use
    bmsg_sync u_sync_trip (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_cmp.main_below_trip),
        .o_sync(below_trip_s)
    );

    bmsg_sync u_sync_batt (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_cmp.main_below_batt),
        .o_sync(below_batt_s)
    );

    // configuration holds until software rewrites it
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            cfg_q.switchover_select <= BMSG_SWITCH_RESET;
            cfg_q.serial_inhibit_in_backup <= BMSG_INHIBIT_RESET;
        end else if (i_cfg_we) begin
            cfg_q <= i_cfg;
        end
    end

    // below the lower of two levels means below both of them
    assign standard_trip = below_trip_s & below_batt_s;
    assign legacy_trip = below_batt_s;

    assign switch_cond = (cfg_q.switchover_select == BMSG_SEL_LEGACY)
        ? legacy_trip : standard_trip;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BMSG_ST_MAIN: begin
                if (switch_cond) begin
                    state_d = BMSG_ST_BACKUP;
                end
            end
            BMSG_ST_BACKUP: begin
                if (!switch_cond) begin
                    state_d = BMSG_ST_MAIN;
                end
            end
            default: begin
                state_d = BMSG_ST_MAIN;
            end
        endcase
    end

    assign in_backup_d = (state_d == BMSG_ST_BACKUP);

    // serial dropped only when inhibit is set and we sit on battery
    assign serial_en_d = !(in_backup_d && (cfg_q.serial_inhibit_in_backup
        == BMSG_INH_ON));

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_q <= BMSG_ST_MAIN;
            o_on_battery <= 1'b0;
            o_serial_enable <= 1'b1;
            o_nvm_access_ok <= 1'b1;
            fout_drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            o_on_battery <= in_backup_d;
            o_serial_enable <= serial_en_d;
            o_nvm_access_ok <= !in_backup_d;
            // no gating by power state: output runs in every mode
            fout_drive_q <= i_interrupt_or_freq_output_assert;
        end
    end

    assign o_cfg = cfg_q;
    // open drain: pin pulled low while output enable is high
    assign o_interrupt_or_freq_output = 1'b0;
    assign o_interrupt_or_freq_output_oe = !fout_drive_q;

endmodule // bmsg_backup_gating

// File: core/bmsg_pkg.sv
package bmsg_pkg;

    // mode select bits as written by software
    typedef struct packed {
        logic serial_inhibit_in_backup;
        logic switchover_select;
    } bmsg_cfg_s;

    // comparator results, each arriving asynchronously from the analog side
    typedef struct packed {
        logic main_below_trip;
        logic main_below_batt;
    } bmsg_cmp_s;

    // power state
    typedef enum logic [1:0] {
        BMSG_ST_MAIN   = 2'b01,
        BMSG_ST_BACKUP = 2'b10
    } bmsg_state_e;

    // reset values of the mode bits: standard switchover, serial kept alive
    localparam logic BMSG_SWITCH_RESET = 1'b0;
    localparam logic BMSG_INHIBIT_RESET = 1'b0;
    localparam logic BMSG_SEL_LEGACY = 1'b1;
    localparam logic BMSG_INH_ON = 1'b1;

    // synchroniser depth
    localparam int BMSG_SYNC_STAGES = 2;

endpackage

// File: core/bmsg_sync.sv
`timescale 1ns/1ps
module bmsg_sync (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // asynchronous level and its synchronised copy
    input wire logic i_async,
    output logic o_sync
);
    import bmsg_pkg::*;

    logic [BMSG_SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[BMSG_SYNC_STAGES-2:0], i_async};
        end
    end

    assign o_sync = stage_q[BMSG_SYNC_STAGES-1];

endmodule // bmsg_sync

// File: testbench/bmsg_chk.sv
`timescale 1ns/1ps
module bmsg_chk import bmsg_pkg::*; (
    input wire logic i_sys_clk, i_reset_n, i_cfg_we, i_interrupt_or_freq_output_assert,
    input wire bmsg_cfg_s i_cfg, o_cfg,
    input wire bmsg_cmp_s i_cmp,
    input wire logic o_on_battery, o_serial_enable, o_nvm_access_ok,
    input wire logic o_interrupt_or_freq_output,
    input wire logic o_interrupt_or_freq_output_oe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    wire inh = o_cfg.serial_inhibit_in_backup;
    wire bat = o_on_battery;
    wire we = i_cfg_we;
    AST_CFG: assert property (we |=> o_cfg == $past(i_cfg))
        else $error("cfg");
    AST_KEEP: assert property ($stable(o_cfg) && !inh |-> o_serial_enable)
        else $error("serial off");
    AST_INH: assert property (
        $stable(o_cfg) && inh |-> o_serial_enable != bat) else $error("serial");
    AST_LEG: assert property (
        (i_cmp == 2'h1 && !we)[*5] |-> bat == o_cfg.switchover_select)
        else $error("legacy");
    AST_STD: assert property ((i_cmp == 2'h3 && !we)[*5] |-> bat)
        else $error("standard");
    AST_MAIN: assert property ((!i_cmp[0] && !we)[*5] |-> !bat)
        else $error("mains");
    AST_PIN: assert property (1 |=> !o_interrupt_or_freq_output &&
        o_interrupt_or_freq_output_oe != $past(i_interrupt_or_freq_output_assert))
        else $error("pin");
    AST_NVM: assert property (o_nvm_access_ok != bat)
        else $error("nvm");
    AST_RST: assert property (disable iff (1'b0) !i_reset_n |=> !o_cfg)
        else $error("reset");
    cover property (bat && !o_serial_enable);
    cover property (bat && o_serial_enable);
    cover property (bat && !o_interrupt_or_freq_output_oe);
endmodule // bmsg_chk
bind bmsg_backup_gating bmsg_chk u_chk (.*);

// File: testbench/bmsg_host.sv
`timescale 1ns/1ps
module bmsg_host import bmsg_pkg::*; (
    input wire logic i_sys_clk, i_go,
    input wire bmsg_cfg_s i_mode,
    output logic o_we,
    output bmsg_cfg_s o_cfg
);
    // battery powered host, so writes may land during backup
    always_ff @(posedge i_sys_clk) begin
        o_we <= i_go;
        o_cfg <= i_go ? i_mode : ~o_cfg;
    end
endmodule // bmsg_host

// File: testbench/backup_mode_serial_gating_bench.sv
`timescale 1ns/1ps
module backup_mode_serial_gating_bench;
    import bmsg_pkg::*;
    logic i_sys_clk = 0, i_reset_n = 0, go = 0, irq = 0, run = 0, pv = 0;
    logic we, bat, ser, nvm, pin, oe, e;
    bmsg_cfg_s mode = 0, cfg, ocfg;
    bmsg_cmp_s cmp = 0;
    logic [3:0] v;
    logic [15:0] lf = 16'h6926;
    int n_mismatch = 0, total_checks = 0;
    bmsg_host host (.i_sys_clk, .i_go(go), .i_mode(mode), .o_we(we),
        .o_cfg(cfg));
    bmsg_backup_gating dut (.i_sys_clk, .i_reset_n, .i_cfg_we(we),
        .i_cfg(cfg), .i_cmp(cmp), .i_interrupt_or_freq_output_assert(irq), .o_cfg(ocfg),
        .o_on_battery(bat), .o_serial_enable(ser), .o_nvm_access_ok(nvm),
        .o_interrupt_or_freq_output(pin), .o_interrupt_or_freq_output_oe(oe));
    initial forever #50 i_sys_clk = ~i_sys_clk;
    task automatic check(input logic [4:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one step of the stimulus register; the seed is fixed so runs repeat
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // backup expected from mode and comparators: legacy looks at battery only
    function automatic logic exp_backup(input logic [3:0] m);
        return m[2] ? m[0] : &m[1:0];
    endfunction
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        if (run)
            check({3'h0, pin, oe}, {3'h0, 1'b0, !pv});
        pv <= irq;
        irq <= lf[0];
        lf <= lfsr_next(lf);
    end
    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_reset_n <= 1;
        @(posedge i_sys_clk) run <= 1;
        // first 16 passes walk every mode against every comparator pair, the other 24 use random values
        for (int k = 0; k < 40; k++) begin
            v = k < 16 ? k[3:0] : lf[3:0];
            @(posedge i_sys_clk) go <= 1;
            mode <= v[3:2];
            cmp <= v[1:0];
            @(posedge i_sys_clk) go <= 0;
            repeat (6) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            e = exp_backup(v);
            check({ocfg, bat, ser, nvm}, {v[3:2], e, !(e & v[3]), !e});
        end
        @(posedge i_sys_clk) i_reset_n <= 0;
        run <= 0;
        @(posedge i_sys_clk) i_reset_n <= 1;
        @(negedge i_sys_clk) check({ocfg, ser, nvm}, 5'h03);
        report_and_stop();
    end
    initial begin
        #(100 * 2000);
        n_mismatch++;
        report_and_stop();
    end
endmodule // backup_mode_serial_gating_bench
